// >>> include/ext_bus_map.vh
/*
  constants for the external memory bus control block: space codes,
  access field widths, reset levels and machine-cycle divider figures.
  assumes: included by bare name from the design files.
*/
`ifndef EXT_BUS_MAP_VH
`define EXT_BUS_MAP_VH

// space codes on the request port
`define SPACE_DATA 2'h0
`define SPACE_PROG 2'h1
`define SPACE_IO 2'h2

// width of the software wait-state count
`define WAIT_W 3
// least wait count that turns on ready detection
`define READY_MIN_WAITS 3'h2

// machine-cycle clock divider: system clocks per half period
`define HALF_CYCLE_CLKS 4'h2

// idle level of the active-low strobes
`define STROBE_IDLE 1'b1

`endif

// >>> src/mc_clock_gen.v
/*
  machine-cycle clock generator: divides the system clock into the
  machine-cycle clock and marks each rising edge with a one-clock tick.
  assumes: one system clock, asynchronous active-high reset.
*/
`timescale 1ns/1ps
`include "ext_bus_map.vh"

module mc_clock_gen #(
  parameter [3:0] HALF_CLKS = `HALF_CYCLE_CLKS
) (
  input wire clk_sys_i,
  input wire rst_i,
  output reg mc_clk_o,
  output wire mc_tick_o
);

  reg [3:0] div_count;

  // half-period counter, toggles the clock level at each wrap
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_count <= 4'h0;
      mc_clk_o <= 1'b0;
    end
    else if (div_count == HALF_CLKS - 4'h1)
    begin
      div_count <= 4'h0;
      mc_clk_o <= ~mc_clk_o;
    end
    else
    begin
      div_count <= div_count + 4'h1;
    end
  end

  // tick in the clock before the output rises: a new machine cycle starts
  assign mc_tick_o = (div_count == HALF_CLKS - 4'h1) && !mc_clk_o;

endmodule

// >>> src/pin_sync2.v
/*
  two-flop synchroniser for the asynchronous pin inputs.
  assumes: inputs come from outside the system clock domain.
*/
`timescale 1ns/1ps

module pin_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1;

  // first stage is read only by the second stage
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stage1 <= RESET_VAL;
      sync_o <= RESET_VAL;
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule

// >>> src/ext_bus_ctrl.v
/*
  external memory bus control: runs external accesses to data, program
  and I/O space with software wait states, ready extension, hold
  arbitration and a float control for every output but the address and data buses.
  assumes: the core requests accesses on the system clock; pins ready,
  hold request and float control are asynchronous and are synchronised
  here; pin drivers resolve each output enable into the pad.
*/
`timescale 1ns/1ps
`include "ext_bus_map.vh"

module ext_bus_ctrl #(
  parameter ADDR_W = 16,
  parameter DATA_W = 16,
  parameter [3:0] HALF_CLKS = `HALF_CYCLE_CLKS
) (
  input wire clk_sys_i,
  input wire rst_i,
  // core request side
  input wire req_valid_i,
  output wire req_ready_o,
  input wire [1:0] req_space_i,
  input wire req_write_i,
  input wire req_fetch_i,
  input wire [ADDR_W-1:0] req_addr_i,
  input wire [DATA_W-1:0] req_wdata_i,
  input wire [`WAIT_W-1:0] wait_count_i,
  output reg done_o,
  output reg [DATA_W-1:0] rdata_o,
  // pins
  input wire ready_i,
  input wire hold_req_n_i,
  input wire float_n_i,
  output reg [ADDR_W-1:0] addr_o,
  output wire addr_oe_o,
  input wire [DATA_W-1:0] data_i,
  output reg [DATA_W-1:0] data_o,
  output wire data_oe_o,
  output reg data_space_sel_n,
  output reg program_space_sel_n,
  output reg io_space_sel_n,
  output reg memory_strobe_n,
  output reg io_strobe_n,
  output reg rw_o,
  output wire ctrl_oe_o,
  output reg bus_grant_ack_n,
  output wire bus_grant_ack_oe_o,
  output reg waitstate_done_n,
  output wire waitstate_done_oe_o,
  output reg fetch_addr_valid_n,
  output wire fetch_addr_valid_oe_o,
  output wire machine_cycle_clock_out,
  output wire mc_clock_oe_o
);

  // sequencer states
  // idle: no access under way, selects and strobes high
  // wait: software wait states counting down, one per machine cycle
  // ready: software waits over, ready pin sampled each machine cycle
  // hold: bus given away to another master, lines floating
  //
  // every state change happens on the system clock edge marked by the
  // machine-cycle tick, so all pin levels change together with the
  // rising edge of the machine-cycle clock output
  //
  // hazard: the synchronised ready lags the pin by two system clocks,
  // which fits well inside one machine cycle of four system clocks;
  // a shorter machine cycle would need a different ready path
  //
  // limitation: hold is granted only between accesses, never inside
  // one, so a long ready extension also delays the hold grant
  //
  // the float control acts only on the output enables; internal state
  // and the access sequencer keep running while the pins float
  //
  // the address bus is left driven under float control, only hold
  // releases it
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_READY = 2'h2;
  localparam [1:0] ST_HOLD = 2'h3;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [`WAIT_W-1:0] waits_left;
  reg [`WAIT_W-1:0] waits_total;
  reg is_write;
  reg [1:0] cur_space;
  wire mc_tick;
  wire ready_s;
  wire hold_n_s;
  wire float_n_s;

  // decides whether an access of the given space uses the memory strobe
  function is_mem_space;
    input [1:0] space;
    begin
      is_mem_space = (space == `SPACE_DATA) || (space == `SPACE_PROG);
    end
  endfunction

  // machine-cycle clock; every bus step advances on its rising edge
  mc_clock_gen #(
    .HALF_CLKS(HALF_CLKS)
  ) u_clk (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .mc_clk_o(machine_cycle_clock_out),
    .mc_tick_o(mc_tick)
  );

  // pin inputs: ready, hold request and float control
  pin_sync2 #(
    .WIDTH(3),
    .RESET_VAL(3'h6)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i({hold_req_n_i, float_n_i, ready_i}),
    .sync_o({hold_n_s, float_n_s, ready_s})
  );

  // next state, advanced once per machine cycle
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (!hold_n_s)
          next_state = ST_HOLD;
        else if (req_valid_i)
          next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (waits_left == {`WAIT_W{1'b0}})
        begin
          // ready only looked at with two or more waits, after they end
          if (waits_total >= `READY_MIN_WAITS)
            next_state = ST_READY;
          else
            next_state = ST_IDLE; // zero or one wait: access ends without ready sampling
        end
      end
      ST_READY:
      begin
        // low ready: one more cycle, then sample again
        if (ready_s)
          next_state = ST_IDLE;
      end
      ST_HOLD:
      begin
        if (hold_n_s)
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // access sequencer and bus pin levels
  // reset parks the block in hold with all strobes and selects high;
  // it leaves hold at the first tick after reset if no hold request
  // stands
  //
  // the access start loads the address, data, selects, strobes and
  // direction in one edge, so no strobe leads its address
  //
  // the access end returns every control line to its idle high level
  // in one edge, and latches read data from the pins in that edge
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= ST_HOLD;
      waits_left <= {`WAIT_W{1'b0}};
      waits_total <= {`WAIT_W{1'b0}};
      is_write <= 1'b0;
      cur_space <= `SPACE_DATA;
      addr_o <= {ADDR_W{1'b0}};
      data_o <= {DATA_W{1'b0}};
      rdata_o <= {DATA_W{1'b0}};
      done_o <= 1'b0;
      data_space_sel_n <= `STROBE_IDLE;
      program_space_sel_n <= `STROBE_IDLE;
      io_space_sel_n <= `STROBE_IDLE;
      memory_strobe_n <= `STROBE_IDLE;
      io_strobe_n <= `STROBE_IDLE;
      rw_o <= 1'b1;
      bus_grant_ack_n <= 1'b1;
      waitstate_done_n <= 1'b1;
      fetch_addr_valid_n <= 1'b1;
    end
    else
    begin
      done_o <= 1'b0;
      if (mc_tick)
      begin
        state <= next_state;
        if (state == ST_IDLE && next_state == ST_WAIT)
        begin
          // start of access: address, select and strobes together
          waits_left <= wait_count_i;
          waits_total <= wait_count_i;
          is_write <= req_write_i;
          cur_space <= req_space_i;
          addr_o <= req_addr_i;
          data_o <= req_wdata_i;
          data_space_sel_n <= !(req_space_i == `SPACE_DATA);
          program_space_sel_n <= !(req_space_i == `SPACE_PROG);
          io_space_sel_n <= !(req_space_i == `SPACE_IO);
          memory_strobe_n <= !is_mem_space(req_space_i);
          io_strobe_n <= !(req_space_i == `SPACE_IO);
          rw_o <= !req_write_i;
          fetch_addr_valid_n <= !(req_fetch_i && req_space_i == `SPACE_PROG);
          // two or more waits: first software wait begins, wait-done goes low
          if (wait_count_i >= `READY_MIN_WAITS)
            waitstate_done_n <= 1'b0;
        end
        else if (state == ST_WAIT)
        begin
          if (waits_left != {`WAIT_W{1'b0}})
            waits_left <= waits_left - {{(`WAIT_W-1){1'b0}}, 1'b1};
          // last software wait begins: wait-done high, looped back it
          // reads high at the first ready sample and so adds no wait
          if (waits_left == {{(`WAIT_W-1){1'b0}}, 1'b1})
            waitstate_done_n <= 1'b1;
        end
        if ((state == ST_WAIT || state == ST_READY) && next_state == ST_IDLE)
        begin
          // access ends: everything back to idle high
          data_space_sel_n <= `STROBE_IDLE;
          program_space_sel_n <= `STROBE_IDLE;
          io_space_sel_n <= `STROBE_IDLE;
          memory_strobe_n <= `STROBE_IDLE;
          io_strobe_n <= `STROBE_IDLE;
          rw_o <= 1'b1;
          fetch_addr_valid_n <= 1'b1;
          waitstate_done_n <= 1'b1;
          done_o <= 1'b1;
          if (!is_write)
            rdata_o <= data_i;
        end
        // acknowledge tracks the hold state
        bus_grant_ack_n <= !(next_state == ST_HOLD);
      end
    end
  end

  // request accepted on the machine-cycle edge that leaves idle
  assign req_ready_o = mc_tick && (state == ST_IDLE) && hold_n_s;

  // control lines float in hold and under float control
  assign ctrl_oe_o = float_n_s && (state != ST_HOLD);
  assign addr_oe_o = state != ST_HOLD;
  // data driven only for write data, never in hold or reset
  assign data_oe_o = (state == ST_WAIT || state == ST_READY) && is_write && !rst_i;
  // remaining outputs float under float control only
  assign bus_grant_ack_oe_o = float_n_s;
  assign waitstate_done_oe_o = float_n_s;
  assign fetch_addr_valid_oe_o = float_n_s;
  assign mc_clock_oe_o = float_n_s;

endmodule

// >>> dv/ext_bus_ctrl_chk.sv
/*
  checker for the external bus control: select, strobe, direction and float relations.
  assumes: bound onto ext_bus_ctrl, one clock domain.
*/
`timescale 1ns/1ps
module ext_bus_ctrl_chk (
  input wire clk_sys_i,
  input wire rst_i,
  input wire float_n_i,
  input wire addr_oe_o,
  input wire data_oe_o,
  input wire data_space_sel_n,
  input wire program_space_sel_n,
  input wire io_space_sel_n,
  input wire memory_strobe_n,
  input wire io_strobe_n,
  input wire rw_o,
  input wire ctrl_oe_o,
  input wire bus_grant_ack_n,
  input wire waitstate_done_n,
  input wire waitstate_done_oe_o,
  input wire fetch_addr_valid_n,
  input wire fetch_addr_valid_oe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // relations between the pin outputs
  one_sel_a: assert property ($countones({data_space_sel_n, program_space_sel_n, io_space_sel_n}) >= 2)
    else $error("two space selects low");
  sel_addr_a: assert property (!(data_space_sel_n & program_space_sel_n & io_space_sel_n) |-> addr_oe_o)
    else $error("select low without address");
  hold_float_a: assert property (!bus_grant_ack_n |-> !ctrl_oe_o && !addr_oe_o && !data_oe_o)
    else $error("lines driven in hold");
  mem_strobe_a: assert property (!memory_strobe_n |-> !data_space_sel_n || !program_space_sel_n)
    else $error("memory strobe outside memory access");
  io_strobe_a: assert property (!io_strobe_n |-> !io_space_sel_n && memory_strobe_n)
    else $error("io strobe outside io access");
  dir_data_a: assert property (data_oe_o == !rw_o)
    else $error("direction and data drive differ");
  fetch_prog_a: assert property (!fetch_addr_valid_n |-> !program_space_sel_n)
    else $error("fetch flag outside program access");
  wait_start_a: assert property ($fell(waitstate_done_n) |-> !memory_strobe_n || !io_strobe_n)
    else $error("wait done low outside access");
  float_all_a: assert property (!float_n_i [*4] |-> !ctrl_oe_o && !waitstate_done_oe_o && !fetch_addr_valid_oe_o)
    else $error("outputs driven while floated");
endmodule

// >>> dv/ext_mem_model.sv
/*
  external memory and io device model: stores writes, returns reads, delays ready.
  assumes: strobe_n_i is the and of both strobes; 16 words, low address bits.
*/
`timescale 1ns/1ps
module ext_mem_model (
  input wire clk_sys_i,
  input wire strobe_n_i,
  input wire rw_o,
  input wire [15:0] addr_o,
  input wire [15:0] data_o,
  input wire [5:0] ready_lag_i,
  output reg ready_i,
  output reg [15:0] data_i
);
  reg [15:0] mem [0:15];
  reg [5:0] cnt;
  integer n;
  initial
  begin
    for (n = 0; n < 16; n = n + 1) mem[n] = 16'h0000;
    cnt = 6'h00;
    ready_i = 1'b0;
    data_i = 16'h0000;
  end
  // ready held low until the lag runs out, low again between accesses
  always @(posedge clk_sys_i)
  begin
    cnt <= strobe_n_i ? 6'h00 : (cnt == 6'h3F ? cnt : cnt + 6'h01);
    ready_i <= !strobe_n_i && (cnt >= ready_lag_i);
    if (!strobe_n_i && !rw_o) mem[addr_o[3:0]] <= data_o;
    data_i <= (!strobe_n_i && rw_o) ? mem[addr_o[3:0]] : ~data_i; // released bus toggles
  end
endmodule

// >>> dv/ext_bus_ctrl_tb.sv
/*
  testbench for the external bus control: random accesses, hold and float.
  assumes: memory model on the pins, optional wait-done loopback onto ready.
*/
`timescale 1ns/1ps
`include "ext_bus_map.vh"
module ext_bus_ctrl_tb;
  reg clk_sys_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, req_write_i = 1'b0, req_fetch_i = 1'b0;
  reg hold_req_n_i = 1'b1, float_n_i = 1'b1, loop = 1'b0, mc_q = 1'b0;
  reg [1:0] req_space_i = 2'h0;
  reg [15:0] req_addr_i = 16'h0000, req_wdata_i = 16'h0000;
  reg [`WAIT_W-1:0] wait_count_i = 3'h0;
  reg [5:0] lag = 6'h00;
  reg [15:0] shadow [0:15];
  reg [16:0] e;
  integer seed = 32'hDBF6B31C, n_fail = 0, check_count = 0, cyc = 0, t0 = 0, tmc = 0, l, i;
  reg [16:0] exp_q [$];
  integer lat_q [$];
  wire req_ready_o, done_o, addr_oe_o, data_oe_o, rw_o, ctrl_oe_o, mdl_ready, machine_cycle_clock_out;
  wire data_space_sel_n, program_space_sel_n, io_space_sel_n, memory_strobe_n, io_strobe_n;
  wire bus_grant_ack_n, bus_grant_ack_oe_o, waitstate_done_n, waitstate_done_oe_o;
  wire fetch_addr_valid_n, fetch_addr_valid_oe_o, mc_clock_oe_o;
  wire [15:0] rdata_o, addr_o, data_i, data_o;
  always #2.5 clk_sys_i = ~clk_sys_i;
  ext_bus_ctrl i_ext_bus_ctrl (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_space_i(req_space_i), .req_write_i(req_write_i), .req_fetch_i(req_fetch_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .wait_count_i(wait_count_i), .done_o(done_o),
    .rdata_o(rdata_o), .ready_i(loop ? waitstate_done_n : mdl_ready), .hold_req_n_i(hold_req_n_i),
    .float_n_i(float_n_i), .addr_o(addr_o), .addr_oe_o(addr_oe_o), .data_i(data_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .data_space_sel_n(data_space_sel_n), .program_space_sel_n(program_space_sel_n),
    .io_space_sel_n(io_space_sel_n), .memory_strobe_n(memory_strobe_n), .io_strobe_n(io_strobe_n), .rw_o(rw_o),
    .ctrl_oe_o(ctrl_oe_o), .bus_grant_ack_n(bus_grant_ack_n), .bus_grant_ack_oe_o(bus_grant_ack_oe_o),
    .waitstate_done_n(waitstate_done_n), .waitstate_done_oe_o(waitstate_done_oe_o),
    .fetch_addr_valid_n(fetch_addr_valid_n), .fetch_addr_valid_oe_o(fetch_addr_valid_oe_o),
    .machine_cycle_clock_out(machine_cycle_clock_out), .mc_clock_oe_o(mc_clock_oe_o));
  ext_mem_model i_ext_mem_model (.clk_sys_i(clk_sys_i), .strobe_n_i(memory_strobe_n & io_strobe_n),
    .rw_o(rw_o), .addr_o(addr_o), .data_o(data_o), .ready_lag_i(lag), .ready_i(mdl_ready), .data_i(data_i));
  task chk(input string nm, input [31:0] seen, input [31:0] want);
    begin
      check_count = check_count + 1;
      if (seen !== want)
      begin
        n_fail = n_fail + 1;
        $display("FAIL %s expected %h seen %h", nm, want, seen);
      end
    end
  endtask
  task wrap_up;
    begin
      if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // one access: request held until taken, then wait for completion
  task acc(input [1:0] sp, input wr, input [15:0] a, input [15:0] d, input [2:0] w);
    integer k;
    begin
      @(posedge clk_sys_i);
      #1 {req_valid_i, req_space_i, req_write_i, req_addr_i, req_wdata_i, wait_count_i} = {1'b1, sp, wr, a, d, w};
      req_fetch_i = (sp == `SPACE_PROG) && !wr;
      if (wr) shadow[a[3:0]] = d;
      exp_q.push_back({!wr, shadow[a[3:0]]});
      lat_q.push_back(w < 2 ? 4 * (w + 1) + 1 : -((4 * (w + 1) + 2) > lag + 2 ? 4 * (w + 1) + 2 : lag + 2));
      k = 0;
      @(posedge clk_sys_i);
      while (req_ready_o !== 1'b1 && k < 400)
      begin
        @(posedge clk_sys_i);
        k = k + 1;
      end
      #1 req_valid_i = 1'b0;
      while (done_o !== 1'b1 && k < 1400)
      begin
        @(posedge clk_sys_i);
        k = k + 1;
      end
      // a stuck access counts as a mismatch
      if (k >= 1400) n_fail = n_fail + 1;
    end
  endtask
  // result watcher and cycle ceiling
  always @(posedge clk_sys_i)
  begin
    cyc = cyc + 1;
    if (cyc > 40000)
    begin
      n_fail = n_fail + 1;
      wrap_up;
    end
    if (!rst_i && machine_cycle_clock_out === 1'b1 && !mc_q)
    begin
      if (tmc > 0) chk("mc period", cyc - tmc, 4);
      tmc = cyc;
    end
    mc_q = machine_cycle_clock_out;
    if (!rst_i && req_ready_o === 1'b1) t0 = cyc;
    if (!rst_i && done_o === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      l = lat_q.pop_front();
      if (e[16]) chk("rdata", rdata_o, e[15:0]);
      if (l > 0) chk("latency", cyc - t0, l);
      else chk("min latency", (cyc - t0) >= -l, 1);
    end
  end
  initial
  begin
    for (i = 0; i < 16; i = i + 1) shadow[i] = 16'h0000;
    repeat (10) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    repeat (12) @(posedge clk_sys_i);
    for (i = 0; i < 40; i = i + 1)
    begin
      loop = $random(seed);
      lag = loop ? 6'h00 : $random(seed);
      acc({$random(seed)} % 3, $random(seed), $random(seed), $random(seed), $random(seed));
    end
    #1 hold_req_n_i = 1'b0;
    i = 0;
    while (bus_grant_ack_n !== 1'b0 && i < 200)
    begin
      @(posedge clk_sys_i);
      i = i + 1;
    end
    chk("hold drive", {bus_grant_ack_n, ctrl_oe_o, addr_oe_o, data_oe_o}, 4'h0);
    #1 hold_req_n_i = 1'b1;
    repeat (20) @(posedge clk_sys_i);
    chk("hold released", bus_grant_ack_n, 1'b1);
    #1 float_n_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1 chk("float", {bus_grant_ack_oe_o, mc_clock_oe_o, waitstate_done_oe_o, ctrl_oe_o}, 4'h0);
    float_n_i = 1'b1;
    repeat (8) @(posedge clk_sys_i);
    acc(`SPACE_IO, 1'b0, 16'h0003, 16'h0000, 3'h0);
    repeat (2) @(posedge clk_sys_i);
    chk("pending results", exp_q.size(), 0);
    wrap_up;
  end
endmodule
bind ext_bus_ctrl ext_bus_ctrl_chk i_ext_bus_ctrl_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .float_n_i(float_n_i),
  .addr_oe_o(addr_oe_o), .data_oe_o(data_oe_o), .data_space_sel_n(data_space_sel_n),
  .program_space_sel_n(program_space_sel_n), .io_space_sel_n(io_space_sel_n), .memory_strobe_n(memory_strobe_n),
  .io_strobe_n(io_strobe_n), .rw_o(rw_o), .ctrl_oe_o(ctrl_oe_o), .bus_grant_ack_n(bus_grant_ack_n),
  .waitstate_done_n(waitstate_done_n), .waitstate_done_oe_o(waitstate_done_oe_o),
  .fetch_addr_valid_n(fetch_addr_valid_n), .fetch_addr_valid_oe_o(fetch_addr_valid_oe_o));
